// ### lsr_defines.svh
// Functional notes
// - All registers 32 bits on management port
// - Unlisted addresses are reserved, read zero
// - Offset zero holds ident string and version
// - 24-bit uptime seconds at offset 3, wraps
// - Seconds derived from management clock cycles
// - Per-lane transmit FIFO flags at 4 to 7
// - Per-lane receive FIFO flags at 8 to B
// - MAC clock kHz at C, PAM4 only
// - Recovered clock kHz at offset D
// - Transmit serial clock kHz at offset E
// - External PLL lock per block, unused read one
// - Integrated PLL: MAC lock bit16, TX bit0
// - Per-lane CDR frequency lock at offset 11
// - Reset controller drives PLL power-down output
`ifndef LSR_DEFINES_SVH
`define LSR_DEFINES_SVH

// Register offsets, word indexed on the management port
`define LSR_OFF_IDENT 16'h0000
`define LSR_OFF_LANES 16'h0001
`define LSR_OFF_UPTIME 16'h0003
`define LSR_OFF_TX_EMPTY 16'h0004
`define LSR_OFF_TX_FULL 16'h0005
`define LSR_OFF_TX_LOW 16'h0006
`define LSR_OFF_TX_HIGH 16'h0007
`define LSR_OFF_RX_EMPTY 16'h0008
`define LSR_OFF_RX_FULL 16'h0009
`define LSR_OFF_RX_LOW 16'h000A
`define LSR_OFF_RX_HIGH 16'h000B
`define LSR_OFF_MAC_KHZ 16'h000C
`define LSR_OFF_RECOV_KHZ 16'h000D
`define LSR_OFF_SERIAL_KHZ 16'h000E
`define LSR_OFF_PLL_LOCK 16'h0010
`define LSR_OFF_CDR_LOCK 16'h0011

// Field positions
`define LSR_IDENT_MSB 31
`define LSR_IDENT_LSB 8
`define LSR_VER_MSB 7
`define LSR_UPTIME_MSB 23
`define LSR_PLL_MAC_BIT 16
`define LSR_PLL_TX_BIT 0

// Reset values
`define LSR_DATA_ZERO 32'h0000_0000
`define LSR_UPTIME_RST 24'h00_0000

// Timing: clock period, one second, measuring gate, power-down hold
`define LSR_CLK_PERIOD_NS 25
`define LSR_SECOND_NS 1000000000
`define LSR_GATE_NS 1000000
`define LSR_PD_HOLD_NS 1000
`define LSR_SECOND_CYCLES (`LSR_SECOND_NS / `LSR_CLK_PERIOD_NS)
`define LSR_GATE_CYCLES (`LSR_GATE_NS / `LSR_CLK_PERIOD_NS)
`define LSR_PD_HOLD_CYCLES ((`LSR_PD_HOLD_NS + `LSR_CLK_PERIOD_NS - 1) / `LSR_CLK_PERIOD_NS)

`endif

// ### lsr_pkg.sv
`default_nettype none
package lsr_pkg;
  // Which PLL arrangement the core was built with
  typedef enum logic {
    LSR_PLL_EXTERNAL = 1'b0,
    LSR_PLL_INTEGRATED = 1'b1
  } lsr_pll_mode_t;

  // Reset controller states for the PLL power-down sequence
  typedef enum logic [1:0] {
    LSR_RC_PWRDN = 2'b00,
    LSR_RC_WAIT = 2'b01,
    LSR_RC_RUN = 2'b10
  } lsr_rc_state_t;
endpackage
`default_nettype wire

// ### lsr_freq_meter.sv
`timescale 1ns/10ps
`default_nettype none
`include "lsr_defines.svh"

// Counts rising edges of a sampled clock over a fixed gate of mclk.
// A 1 ms gate makes the edge count read directly in kHz.
module lsr_freq_meter #(
  parameter int unsigned GATE_CYCLES = `LSR_GATE_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  input wire logic clk_sample,
  output logic [31:0] rate_khz_q
);
  import lsr_pkg::*;

  localparam int GW = $clog2(GATE_CYCLES);

  logic s1_q; // First sync stage, read only by s2_q
  logic s2_q; // Second sync stage
  logic s3_q; // Delayed copy for edge detection
  logic rise; // One-cycle pulse per rising edge
  logic [GW-1:0] gate_q; // Gate cycle counter
  logic gate_end; // Last cycle of the gate
  logic [31:0] edges_q; // Edges seen in this gate

  // Synchroniser; only rates below half of mclk are measured correctly
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
    end
    else
    begin
      s1_q <= clk_sample;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  assign rise = s2_q & ~s3_q;
  assign gate_end = (gate_q == GW'(GATE_CYCLES - 1));

  // Gate timer, free running
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      gate_q <= '0;
    else if (gate_end)
      gate_q <= '0;
    else
      gate_q <= gate_q + 1'b1;
  end

  // Edge count and result latch at the end of each gate
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      edges_q <= `LSR_DATA_ZERO;
      rate_khz_q <= `LSR_DATA_ZERO;
    end
    else if (gate_end)
    begin
      // Edge landing on the last gate cycle still counts
      edges_q <= `LSR_DATA_ZERO;
      rate_khz_q <= edges_q + {31'h0000_0000, rise};
    end
    else
      edges_q <= edges_q + {31'h0000_0000, rise};
  end

  // Result moves only at a gate boundary
  rate_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (rate_khz_q != $past(rate_khz_q)) |-> $past(gate_end))
    else $error("rate changed outside gate end");

endmodule // lsr_freq_meter
`default_nettype wire

// ### lsr_bank.sv
`timescale 1ns/10ps
`default_nettype none
`include "lsr_defines.svh"

// Read-only status and identification bank of the serial link core,
// plus the power-down side of the external transmit PLL interface.
module lsr_bank #(
  parameter int unsigned NUM_LANES = 4,
  parameter lsr_pkg::lsr_pll_mode_t PLL_MODE = lsr_pkg::LSR_PLL_EXTERNAL,
  parameter bit PAM4_MODE = 1'b0,
  parameter logic [23:0] ID_STRING = 24'h4C4E4B, // Arbitrary value
  parameter logic [7:0] VERSION = 8'h01,
  parameter int unsigned SECOND_CYCLES = `LSR_SECOND_CYCLES,
  parameter int unsigned GATE_CYCLES = `LSR_GATE_CYCLES
) (
  input wire logic mclk,
  input wire logic sys_rst,
  // Management port, word addressed
  input wire logic [15:0] mgmt_address,
  input wire logic mgmt_read,
  input wire logic mgmt_write,
  input wire logic [31:0] mgmt_writedata,
  output logic [31:0] mgmt_readdata,
  output logic mgmt_readdatavalid,
  output logic mgmt_waitrequest,
  // Per-lane FIFO status from the data path
  input wire logic [NUM_LANES-1:0] tx_fifo_empty,
  input wire logic [NUM_LANES-1:0] tx_fifo_full,
  input wire logic [NUM_LANES-1:0] tx_fifo_low,
  input wire logic [NUM_LANES-1:0] tx_fifo_high,
  input wire logic [NUM_LANES-1:0] rx_fifo_empty,
  input wire logic [NUM_LANES-1:0] rx_fifo_full,
  input wire logic [NUM_LANES-1:0] rx_fifo_low,
  input wire logic [NUM_LANES-1:0] rx_fifo_high,
  input wire logic [NUM_LANES-1:0] cdr_cdr_lock_status,
  // Clocks to be measured
  input wire logic mac_clk,
  input wire logic rx_recovered_clk,
  input wire logic [NUM_LANES-1:0] tx_serial_clk,
  // PLL interface
  input wire logic tx_pll_locked,
  input wire logic tx_pll_cal_busy,
  input wire logic mac_pll_locked,
  output logic tx_pll_powerdown
);
  import lsr_pkg::*;

  localparam int SW = $clog2(SECOND_CYCLES);
  localparam int PW = 8;
  localparam logic [PW-1:0] PD_HOLD = PW'(`LSR_PD_HOLD_CYCLES - 1);

  logic [NUM_LANES-1:0] tx_empty_q, tx_full_q, tx_low_q, tx_high_q; // Sampled TX flags
  logic [NUM_LANES-1:0] rx_empty_q, rx_full_q, rx_low_q, rx_high_q; // Sampled RX flags
  logic [NUM_LANES-1:0] cdr_lock_q; // Sampled CDR lock
  logic tx_lock_q; // Sampled TX PLL lock
  logic cal_busy_q; // Sampled calibration busy
  logic mac_lock_q; // Sampled MAC PLL lock
  logic [SW-1:0] tick_q; // Cycles within the current second
  logic sec_tick; // Last cycle of a second
  logic [23:0] uptime_q; // Seconds since reset
  logic [31:0] mac_khz, recov_khz, serial_khz; // Meter results
  logic [31:0] pll_word; // Assembled PLL lock register
  logic [31:0] rd_d; // Decoded read value
  logic [31:0] rd_q; // Read data register
  logic rdv_q; // Read data valid
  lsr_rc_state_t rc_q; // Reset controller state
  logic [PW-1:0] pd_cnt_q; // Power-down hold counter

  // The bank never stalls: every read answers next cycle
  assign mgmt_waitrequest = 1'b0;
  assign mgmt_readdata = rd_q;
  assign mgmt_readdatavalid = rdv_q;

  // Sample status inputs so reads see one coherent clock edge
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      tx_empty_q <= '0;
      tx_full_q <= '0;
      tx_low_q <= '0;
      tx_high_q <= '0;
      rx_empty_q <= '0;
      rx_full_q <= '0;
      rx_low_q <= '0;
      rx_high_q <= '0;
      cdr_lock_q <= '0;
      tx_lock_q <= 1'b0;
      cal_busy_q <= 1'b0;
      mac_lock_q <= 1'b0;
    end
    else
    begin
      tx_empty_q <= tx_fifo_empty;
      tx_full_q <= tx_fifo_full;
      tx_low_q <= tx_fifo_low;
      tx_high_q <= tx_fifo_high;
      rx_empty_q <= rx_fifo_empty;
      rx_full_q <= rx_fifo_full;
      rx_low_q <= rx_fifo_low;
      rx_high_q <= rx_fifo_high;
      cdr_lock_q <= cdr_cdr_lock_status;
      tx_lock_q <= tx_pll_locked;
      cal_busy_q <= tx_pll_cal_busy;
      mac_lock_q <= mac_pll_locked;
    end
  end

  // One-second prescaler on the management clock
  assign sec_tick = (tick_q == SW'(SECOND_CYCLES - 1));

  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      tick_q <= '0;
    else if (sec_tick)
      tick_q <= '0;
    else
      tick_q <= tick_q + 1'b1;
  end

  // Uptime seconds; 24 bits wrap naturally after about 194 days
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      uptime_q <= `LSR_UPTIME_RST;
    else if (sec_tick)
      uptime_q <= uptime_q + 1'b1;
  end

  // Clock rate meters; serial clocks above half of mclk alias
  lsr_freq_meter #(.GATE_CYCLES(GATE_CYCLES)) u_mac_meter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_sample(mac_clk),
    .rate_khz_q(mac_khz)
  );

  lsr_freq_meter #(.GATE_CYCLES(GATE_CYCLES)) u_recov_meter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_sample(rx_recovered_clk),
    .rate_khz_q(recov_khz)
  );

  // Lane 0 stands for all lanes, they share one PLL
  lsr_freq_meter #(.GATE_CYCLES(GATE_CYCLES)) u_serial_meter (
    .mclk(mclk),
    .sys_rst(sys_rst),
    .clk_sample(tx_serial_clk[0]),
    .rate_khz_q(serial_khz)
  );

  // PLL lock word per variant
  always_comb
  begin
    if (PLL_MODE == LSR_PLL_EXTERNAL)
    begin
      // Only one transceiver block is used, all others read one
      pll_word = 32'hFFFF_FFFF;
      pll_word[`LSR_PLL_TX_BIT] = tx_lock_q;
    end
    else
    begin
      pll_word = `LSR_DATA_ZERO;
      pll_word[`LSR_PLL_MAC_BIT] = mac_lock_q;
      pll_word[`LSR_PLL_TX_BIT] = tx_lock_q;
    end
  end

  // Read address decode; unlisted offsets read zero
  always_comb
  begin
    rd_d = `LSR_DATA_ZERO;
    if (mgmt_address == `LSR_OFF_IDENT)
      rd_d = {ID_STRING, VERSION};
    else if (mgmt_address == `LSR_OFF_LANES)
      rd_d = 32'(NUM_LANES);
    else if (mgmt_address == `LSR_OFF_UPTIME)
      rd_d = {8'h00, uptime_q};
    else if (mgmt_address == `LSR_OFF_TX_EMPTY)
      rd_d[NUM_LANES-1:0] = tx_empty_q;
    else if (mgmt_address == `LSR_OFF_TX_FULL)
      rd_d[NUM_LANES-1:0] = tx_full_q;
    else if (mgmt_address == `LSR_OFF_TX_LOW)
      rd_d[NUM_LANES-1:0] = tx_low_q;
    else if (mgmt_address == `LSR_OFF_TX_HIGH)
      rd_d[NUM_LANES-1:0] = tx_high_q;
    else if (mgmt_address == `LSR_OFF_RX_EMPTY)
      rd_d[NUM_LANES-1:0] = rx_empty_q;
    else if (mgmt_address == `LSR_OFF_RX_FULL)
      rd_d[NUM_LANES-1:0] = rx_full_q;
    else if (mgmt_address == `LSR_OFF_RX_LOW)
      rd_d[NUM_LANES-1:0] = rx_low_q;
    else if (mgmt_address == `LSR_OFF_RX_HIGH)
      rd_d[NUM_LANES-1:0] = rx_high_q;
    else if (mgmt_address == `LSR_OFF_MAC_KHZ)
      rd_d = PAM4_MODE ? mac_khz : `LSR_DATA_ZERO;
    else if (mgmt_address == `LSR_OFF_RECOV_KHZ)
      rd_d = recov_khz;
    else if (mgmt_address == `LSR_OFF_SERIAL_KHZ)
      rd_d = serial_khz;
    else if (mgmt_address == `LSR_OFF_PLL_LOCK)
      rd_d = pll_word;
    else if (mgmt_address == `LSR_OFF_CDR_LOCK)
      rd_d[NUM_LANES-1:0] = cdr_lock_q;
    else
      rd_d = `LSR_DATA_ZERO;
  end

  // Read response; writes are accepted and dropped
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rd_q <= `LSR_DATA_ZERO;
      rdv_q <= 1'b0;
    end
    else
    begin
      rdv_q <= mgmt_read;
      if (mgmt_read)
        rd_q <= rd_d;
    end
  end

  // Reset controller: hold power-down, then wait for a calm, locked PLL
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
    begin
      rc_q <= LSR_RC_PWRDN;
      pd_cnt_q <= '0;
    end
    else
    begin
      case (rc_q)
        LSR_RC_PWRDN:
        begin
          // Minimum power-down pulse before release
          if (pd_cnt_q == PD_HOLD)
            rc_q <= LSR_RC_WAIT;
          else
            pd_cnt_q <= pd_cnt_q + 1'b1;
        end
        LSR_RC_WAIT:
        begin
          pd_cnt_q <= '0;
          if (tx_lock_q && !cal_busy_q)
            rc_q <= LSR_RC_RUN;
        end
        LSR_RC_RUN:
        begin
          // Loss of lock falls back to waiting, no new power cycle
          if (!tx_lock_q)
            rc_q <= LSR_RC_WAIT;
        end
        default:
          rc_q <= LSR_RC_PWRDN;
      endcase
    end
  end

  // Power-down request is high through reset and the hold phase
  always_ff @(posedge mclk or posedge sys_rst)
  begin
    if (sys_rst)
      tx_pll_powerdown <= 1'b1;
    else
      tx_pll_powerdown <= (rc_q == LSR_RC_PWRDN) && (pd_cnt_q != PD_HOLD);
  end

  // Checks
  rd_latency_a: assert property (@(posedge mclk) disable iff (sys_rst)
    mgmt_read |=> mgmt_readdatavalid)
    else $error("read not answered next cycle");

  write_silent_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (mgmt_write && !mgmt_read) |=> !mgmt_readdatavalid && $stable(mgmt_readdata))
    else $error("write disturbed read port");

  ident_value_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (mgmt_read && mgmt_address == `LSR_OFF_IDENT)
      |=> mgmt_readdata == {ID_STRING, VERSION})
    else $error("ident register wrong");

  reserved_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (mgmt_read && (mgmt_address == 16'h0002 || mgmt_address == 16'h000F))
      |=> mgmt_readdata == `LSR_DATA_ZERO)
    else $error("reserved offset not zero");

  uptime_step_a: assert property (@(posedge mclk) disable iff (sys_rst)
    sec_tick |=> uptime_q == $past(uptime_q) + 24'h00_0001)
    else $error("uptime did not advance");

  uptime_hold_a: assert property (@(posedge mclk) disable iff (sys_rst)
    !sec_tick |=> $stable(uptime_q))
    else $error("uptime moved without tick");

  pll_spare_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (PLL_MODE == LSR_PLL_EXTERNAL && mgmt_read && mgmt_address == `LSR_OFF_PLL_LOCK)
      |=> mgmt_readdata[31:1] == 31'h7FFF_FFFF)
    else $error("unused PLL lock bits not one");

  cdr_lane_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (mgmt_read && mgmt_address == `LSR_OFF_CDR_LOCK)
      |-> ##1 mgmt_readdata[NUM_LANES-1:0] == $past(cdr_cdr_lock_status, 2))
    else $error("CDR lock read mismatch");

  pd_release_a: assert property (@(posedge mclk) disable iff (sys_rst)
    $fell(tx_pll_powerdown) |-> $past(rc_q) == LSR_RC_PWRDN && rc_q == LSR_RC_WAIT)
    else $error("power-down released early");

  pd_stays_a: assert property (@(posedge mclk) disable iff (sys_rst)
    (rc_q != LSR_RC_PWRDN) |=> !tx_pll_powerdown)
    else $error("power-down reasserted");

  ident_read_c: cover property (@(posedge mclk) disable iff (sys_rst)
    mgmt_read && mgmt_address == `LSR_OFF_IDENT ##1 mgmt_readdatavalid);

  sec_tick_c: cover property (@(posedge mclk) disable iff (sys_rst) sec_tick);

  pll_run_c: cover property (@(posedge mclk) disable iff (sys_rst)
    rc_q == LSR_RC_WAIT ##1 rc_q == LSR_RC_RUN);

endmodule // lsr_bank
`default_nettype wire

// ### lsr_pll_model.sv
`timescale 1ns/10ps
`default_nettype none

// Behavioural external transmit PLL facing the bank's PLL interface
module lsr_pll_model #(
  parameter int unsigned NUM_LANES = 4,
  parameter int unsigned CAL_NS = 500
) (
  input wire logic tx_pll_powerdown,
  input wire logic lose_lock,
  output var logic tx_pll_locked,
  output var logic tx_pll_cal_busy,
  output var logic [NUM_LANES-1:0] tx_serial_clk
);
  logic ser_q; // 8 MHz serial clock, stopped while powered down

  // Serial clock runs only once power-down is released; the 5 ns offset keeps
  // every toggle clear of mclk edges, so the bank's sampling never races it
  always
  begin
    ser_q = 1'b0;
    wait (tx_pll_powerdown === 1'b0);
    #5;
    while (tx_pll_powerdown !== 1'b1)
    begin
      #62.5;
      ser_q = ~ser_q;
    end
  end
  assign tx_serial_clk = {NUM_LANES{ser_q}};

  // Calibrate after power-up, then lock until told to drop it
  always
  begin
    tx_pll_locked = 1'b0;
    tx_pll_cal_busy = 1'b0;
    wait (tx_pll_powerdown === 1'b0);
    tx_pll_cal_busy = 1'b1;
    #(CAL_NS);
    tx_pll_cal_busy = 1'b0;
    tx_pll_locked = 1'b1;
    wait (lose_lock === 1'b1 || tx_pll_powerdown === 1'b1);
    tx_pll_locked = 1'b0;
    wait (lose_lock === 1'b0);
  end
endmodule // lsr_pll_model

`default_nettype wire

// ### lsr_bank_tb.sv
`timescale 1ns/10ps
`default_nettype none

module lsr_bank_tb;
  import lsr_pkg::*;

  logic mclk = 1'b0;
  logic sys_rst = 1'b1;
  logic [15:0] mgmt_address = 16'h0000;
  logic mgmt_read = 1'b0;
  logic mgmt_write = 1'b0;
  logic [31:0] mgmt_writedata = 32'h0000_0000;
  logic [31:0] mgmt_readdata;
  logic mgmt_readdatavalid;
  logic mgmt_waitrequest;
  logic [3:0] txe = 4'h0, txf = 4'h0, txl = 4'h0, txh = 4'h0; // Transmit FIFO flags
  logic [3:0] rxe = 4'h0, rxf = 4'h0, rxl = 4'h0, rxh = 4'h0; // Receive FIFO flags
  logic [3:0] cdr = 4'h0; // Per-lane frequency lock
  logic mac_clk = 1'b0; // 0.8 MHz, one edge per 50-cycle gate
  logic mac_lock = 1'b0; // MAC PLL lock for the integrated variant
  logic [31:0] alt_rdata; // Read data of the integrated PAM4 variant
  logic rec_clk = 1'b0; // 4 MHz, reads as 5 per 50-cycle gate
  logic lose_lock = 1'b0; // Commands a lock loss in the PLL model
  logic pll_locked, pll_busy, pll_pd;
  logic [3:0] ser_clk;
  int mismatches = 0;
  int check_count = 0;

  always #12.5 mclk = ~mclk;
  always #625 mac_clk = ~mac_clk;
  always #125 rec_clk = ~rec_clk;

  // Short second and gate keep the run brief
  lsr_bank #(.SECOND_CYCLES(100), .GATE_CYCLES(50)) DUT (
    .mclk(mclk), .sys_rst(sys_rst), .mgmt_address(mgmt_address), .mgmt_read(mgmt_read),
    .mgmt_write(mgmt_write), .mgmt_writedata(mgmt_writedata), .mgmt_readdata(mgmt_readdata),
    .mgmt_readdatavalid(mgmt_readdatavalid), .mgmt_waitrequest(mgmt_waitrequest),
    .tx_fifo_empty(txe), .tx_fifo_full(txf), .tx_fifo_low(txl), .tx_fifo_high(txh),
    .rx_fifo_empty(rxe), .rx_fifo_full(rxf), .rx_fifo_low(rxl), .rx_fifo_high(rxh),
    .cdr_cdr_lock_status(cdr), .mac_clk(mac_clk), .rx_recovered_clk(rec_clk),
    .tx_serial_clk(ser_clk), .tx_pll_locked(pll_locked), .tx_pll_cal_busy(pll_busy),
    .mac_pll_locked(1'b0),
    .tx_pll_powerdown(pll_pd));

  lsr_pll_model #(.NUM_LANES(4)) pll (.tx_pll_powerdown(pll_pd), .lose_lock(lose_lock),
    .tx_pll_locked(pll_locked), .tx_pll_cal_busy(pll_busy), .tx_serial_clk(ser_clk));

  // Integrated-PLL PAM4 variant on the same bus; its transmit PLL inputs are tied low, MAC PLL lock is driven by mac_lock
  lsr_bank #(.PLL_MODE(LSR_PLL_INTEGRATED), .PAM4_MODE(1'b1), .SECOND_CYCLES(100),
    .GATE_CYCLES(50)) DUT_ALT (
    .mclk(mclk), .sys_rst(sys_rst), .mgmt_address(mgmt_address), .mgmt_read(mgmt_read),
    .mgmt_write(mgmt_write), .mgmt_writedata(mgmt_writedata), .mgmt_readdata(alt_rdata),
    .mgmt_readdatavalid(), .mgmt_waitrequest(),
    .tx_fifo_empty(txe), .tx_fifo_full(txf), .tx_fifo_low(txl), .tx_fifo_high(txh),
    .rx_fifo_empty(rxe), .rx_fifo_full(rxf), .rx_fifo_low(rxl), .rx_fifo_high(rxh),
    .cdr_cdr_lock_status(cdr), .mac_clk(mac_clk), .rx_recovered_clk(rec_clk),
    .tx_serial_clk(4'h0), .tx_pll_locked(1'b0), .tx_pll_cal_busy(1'b0),
    .mac_pll_locked(mac_lock),
    .tx_pll_powerdown());

  // One comparison, counted, reported at once on mismatch
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
      mismatches++;
    end
  endtask

  // Single read; answer must pulse for exactly one cycle
  task automatic rd(input logic [15:0] a, output logic [31:0] d);
    int n;
    n = 0;
    @(posedge mclk);
    mgmt_read <= 1'b1;
    mgmt_address <= a;
    @(posedge mclk);
    mgmt_read <= 1'b0;
    #1;
    while (mgmt_readdatavalid !== 1'b1 && n < 4)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({31'h0, mgmt_readdatavalid}, 32'h1);
    chk({31'h0, mgmt_waitrequest}, 32'h0);
    d = mgmt_readdata;
    @(posedge mclk);
    #1;
    chk({31'h0, mgmt_readdatavalid}, 32'h0);
  endtask

  // Write strobe; never answered
  task automatic wr(input logic [15:0] a, input logic [31:0] v);
    @(posedge mclk);
    mgmt_write <= 1'b1;
    mgmt_address <= a;
    mgmt_writedata <= v;
    @(posedge mclk);
    mgmt_write <= 1'b0;
    #1;
    chk({31'h0, mgmt_readdatavalid}, 32'h0);
  endtask

  // Power-down held through reset and the 40-cycle hold, then dropped
  task automatic t_reset();
    int n;
    n = 0;
    #1;
    chk({31'h0, pll_pd}, 32'h1);
    chk(mgmt_readdata, 32'h0);
    @(posedge mclk);
    sys_rst <= 1'b0;
    repeat (39) @(posedge mclk);
    #1;
    chk({31'h0, pll_pd}, 32'h1);
    while (pll_pd !== 1'b0 && n < 3)
    begin
      @(posedge mclk);
      #1;
      n++;
    end
    chk({31'h0, pll_pd}, 32'h0);
  endtask

  // Identity, lane count and reserved places, read one after another with strobes three cycles apart
  task automatic t_ident();
    logic [15:0] off [6] = '{16'h0000, 16'h0001, 16'h0002, 16'h000F, 16'h0012, 16'hFFFF};
    logic [31:0] exp [6] = '{32'h4C4E_4B01, 32'h4, 32'h0, 32'h0, 32'h0, 32'h0};
    logic [31:0] d;
    for (int i = 0; i < 6; i++)
    begin
      rd(off[i], d);
      chk(d, exp[i]);
    end
  endtask

  // Distinct per-lane patterns on every flag register, then inverted
  task automatic t_flags();
    logic [3:0] p [9] = '{4'h1, 4'h2, 4'h4, 4'h8, 4'h3, 4'h6, 4'hC, 4'h9, 4'h5};
    logic [15:0] off [9] = '{16'h4, 16'h5, 16'h6, 16'h7, 16'h8, 16'h9, 16'hA, 16'hB, 16'h11};
    logic [3:0] m;
    logic [31:0] d;
    for (int k = 0; k < 2; k++)
    begin
      m = (k == 1) ? 4'hF : 4'h0;
      @(posedge mclk);
      {txe, txf, txl, txh} <= {p[0] ^ m, p[1] ^ m, p[2] ^ m, p[3] ^ m};
      {rxe, rxf, rxl, rxh, cdr} <= {p[4] ^ m, p[5] ^ m, p[6] ^ m, p[7] ^ m, p[8] ^ m};
      repeat (2) @(posedge mclk);
      for (int i = 0; i < 9; i++)
      begin
        rd(off[i], d);
        chk(d, {28'h0, p[i] ^ m});
      end
    end
  endtask

  // Read strobes 300 edges apart see exactly three ticks; top byte stays clear
  task automatic t_uptime();
    logic [31:0] a;
    logic [31:0] b;
    rd(16'h3, a);
    repeat (297) @(posedge mclk);
    rd(16'h3, b);
    chk(b - a, 32'h3);
    chk(b & 32'hFF00_0000, 32'h0);
  endtask

  // Edge counts over the shortened gate
  task automatic t_meters();
    logic [31:0] d;
    rd(16'hC, d);
    chk(d, 32'h0);
    rd(16'hD, d);
    chk(d, 32'h5);
    rd(16'hE, d);
    chk(d, 32'hA);
  endtask

  // Lock bit follows the PLL; unused blocks read one; no new power-down
  task automatic t_pll();
    logic [31:0] d;
    rd(16'h10, d);
    chk(d, 32'hFFFF_FFFF);
    @(posedge mclk);
    lose_lock <= 1'b1;
    repeat (3) @(posedge mclk);
    rd(16'h10, d);
    chk(d, 32'hFFFF_FFFE);
    chk({31'h0, pll_pd}, 32'h0);
    @(posedge mclk);
    lose_lock <= 1'b0;
    repeat (30) @(posedge mclk);
    rd(16'h10, d);
    chk(d, 32'hFFFF_FFFF);
  endtask

  // Writes to read-only places change nothing
  task automatic t_write();
    logic [31:0] d;
    wr(16'h0, 32'hFFFF_FFFF);
    wr(16'h1, 32'h0000_0000);
    rd(16'h0, d);
    chk(d, 32'h4C4E_4B01);
    rd(16'h1, d);
    chk(d, 32'h4);
  endtask

  // Integrated PAM4 variant: MAC rate, MAC lock in bit 16, tied serial clock
  task automatic t_variant();
    logic [31:0] d;
    rd(16'hC, d);
    chk(alt_rdata, 32'h1);
    @(posedge mclk);
    mac_lock <= 1'b1;
    repeat (2) @(posedge mclk);
    rd(16'h10, d);
    chk(alt_rdata, 32'h0001_0000);
    @(posedge mclk);
    mac_lock <= 1'b0;
    repeat (2) @(posedge mclk);
    rd(16'h10, d);
    chk(alt_rdata, 32'h0);
    rd(16'hE, d);
    chk(alt_rdata, 32'h0);
  endtask

  // Counts line, verdict, end of run
  task automatic give_verdict();
    $display("checks=%0d mismatches=%0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask

  // Main sequence
  initial
  begin
    repeat (2) @(posedge mclk);
    t_reset();
    t_ident();
    t_flags();
    t_uptime();
    t_meters();
    t_pll();
    t_write();
    t_variant();
    give_verdict();
  end

  // Watchdog well beyond the expected few hundred cycles
  initial
  begin
    #400000;
    mismatches++;
    $display("[ERR] t=%0t watchdog expired", $time);
    give_verdict();
  end
endmodule // lsr_bank_tb

`default_nettype wire
